/* shared/wiper_port_pkg.sv */
// constants, types and helpers shared by the quad wiper five-wire port
// assumes one core clock domain plus the port clock of the serial link
package wiper_port_pkg;

	// wiper geometry and word layout
	localparam int         POT_COUNT   = 4;      // potentiometers in the device
	localparam int         POS_W       = 6;      // position field width
	localparam int         SEL_W       = 2;      // potentiometer index width
	localparam int         WORD_W      = 8;      // one serial word
	localparam int         SNAP_W      = 32;     // all four read words
	localparam logic [5:0] WIPER_MID   = 6'h20;  // value after reset
	localparam logic [5:0] WIPER_MAX   = 6'h3F;  // wiper at high end terminal
	localparam logic [5:0] WIPER_MIN   = 6'h00;  // wiper at low end terminal

	// serial framing counts
	localparam logic [3:0] WORD_BITS   = 4'h8;   // bits per word
	localparam logic [3:0] BITS_RESET  = 4'h0;   // bit counter after reset
	localparam logic [2:0] MAX_WORDS   = 3'h4;   // words applied per frame
	localparam logic [2:0] WORDS_SAT   = 3'h7;   // word counter saturation
	localparam logic [5:0] READ_BITS   = 6'h20;  // bits shifted out per frame

	// buffering and synchronisers
	localparam int         FIFO_DEPTH  = 4;      // words held between crossing and wipers
	localparam logic [2:0] SYNC_RESET  = 3'h0;   // synchroniser chain after reset

	typedef logic [5:0] pos_t;
	typedef logic [7:0] word_t;

	// filtered level of a three-stage chain: change once stages two and three agree
	function automatic logic sync_filter(input logic [2:0] chain, input logic held);
		sync_filter = (chain[1] == chain[2]) ? chain[2] : held;
	endfunction

	// wire layout of a word: index in the high bits, position in the low bits
	function automatic word_t pack_word(input logic [1:0] sel, input pos_t pos);
		pack_word = {sel, pos};
	endfunction

endpackage

/* rtl/quad_wiper_five_wire_port.sv */
// five-wire shift-register port for four wiper position registers, with its fifo
// assumes the port clock is stopped between frames and comes from the controller
`timescale 1ns/1ps

// small fifo between the link crossing and the wiper registers
module word_fifo
	import wiper_port_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage words
		logic [AW-1:0]               wp;   // write pointer
		logic [AW-1:0]               rp;   // read pointer
		logic [AW:0]                 cnt;  // words held
	} fifo_state_t;

	fifo_state_t cur;       // registered state
	fifo_state_t next_cur;  // next state
	logic        do_push;   // word accepted
	logic        do_pop;    // word leaves

	assign in_ready  = (cur.cnt != (AW+1)'(DEPTH));
	assign out_valid = (cur.cnt != '0);
	assign out_data  = cur.mem[cur.rp];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	// pointer and count update
	always_comb
	begin
		next_cur = cur;
		if (do_push)
		begin
			next_cur.mem[cur.wp] = in_data;
			next_cur.wp          = AW'(cur.wp + 1'b1);
		end
		if (do_pop)
			next_cur.rp = AW'(cur.rp + 1'b1);
		// count moves only when exactly one side acts
		if (do_push && !do_pop)
			next_cur.cnt = (AW+1)'(cur.cnt + 1'b1);
		else if (do_pop && !do_push)
			next_cur.cnt = (AW+1)'(cur.cnt - 1'b1);
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end
endmodule

module quad_wiper_five_wire_port
	import wiper_port_pkg::*;
(
	// core clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// serial port pins
	input  wire logic       interface_select,
	input  wire logic       port_active,
	input  wire logic       read_write,
	input  wire logic       serial_clk,
	input  wire logic       serial_in,
	output logic            cascade_out,
	// wiper positions
	output logic [5:0]      wiper_pos0,
	output logic [5:0]      wiper_pos1,
	output logic [5:0]      wiper_pos2,
	output logic [5:0]      wiper_pos3,
	// end terminal selects
	output logic [3:0]      at_high_end,
	output logic [3:0]      at_low_end
);
	// link state on the rising port clock edge
	typedef struct packed {
		logic [3:0] bit_cnt;  // bits of the current word
		logic [2:0] words;    // completed words this frame
		word_t      shift;    // incoming bits
		logic       dir;      // captured direction, high reads
		logic       dir_ok;   // direction has been captured
	} rise_state_t;

	// link state on the falling port clock edge
	typedef struct packed {
		word_t      hold;     // last finished word
		logic       wtog;     // flips per finished word
		logic       rtog;     // flips per read bit shifted
	} fall_state_t;

	// core clock state
	typedef struct packed {
		logic [2:0]            act_sy;   // activate synchroniser
		logic [2:0]            dir_sy;   // direction synchroniser
		logic [2:0]            din_sy;   // serial input synchroniser
		logic [2:0]            sel_sy;   // interface select synchroniser
		logic [2:0]            wtog_sy;  // word event synchroniser
		logic [2:0]            rtog_sy;  // read event synchroniser
		logic                  act_f;    // filtered activate
		logic                  din_f;    // filtered serial input
		logic                  sel_f;    // filtered interface select
		logic                  wtog_f;   // filtered word toggle
		logic                  rtog_f;   // filtered read toggle
		logic                  dir_c;    // direction of this frame
		logic [SNAP_W-1:0]     snap;     // read words frozen at frame start
		logic [5:0]            rd_idx;   // read bits already shifted
		logic                  pend;     // word waiting for the fifo
		word_t                 pend_word;
		logic [3:0][5:0]       wiper;    // position registers
		logic [3:0]            hi;       // wiper at high end
		logic [3:0]            lo;       // wiper at low end
		logic                  cascade;  // cascade output
	} core_state_t;

	rise_state_t rise;        // registered rising-edge state
	rise_state_t next_rise;   // next rising-edge state
	fall_state_t fall;        // registered falling-edge state
	fall_state_t next_fall;   // next falling-edge state
	core_state_t cur;         // registered core state
	core_state_t next_cur;    // next core state
	logic        link_rst_n;  // rising-edge link state held clear outside frames
	logic        act_new;     // filtered activate after this edge
	logic        dir_new;     // filtered direction after this edge
	logic        din_new;     // filtered serial input after this edge
	logic        sel_new;     // filtered interface select after this edge
	logic        wtog_new;    // filtered word toggle after this edge
	logic        rtog_new;    // filtered read toggle after this edge
	logic        act_rise;    // frame starts this cycle
	logic        fifo_ready;  // fifo can take the pending word
	logic        drain_ok;    // wiper registers may take a word
	logic        pop_valid;   // fifo holds a word
	word_t       pop_word;    // oldest fifo word
	logic        pop;         // word applied this cycle

	// a frame exists only while activate is high and this port is selected
	assign link_rst_n = rst_n & port_active & ~interface_select;

	// rising edge: sample input bits and count words
	always_comb
	begin
		next_rise        = rise;
		next_rise.dir_ok = 1'b1;
		// direction is taken once at the first clock of the frame
		if (!rise.dir_ok)
			next_rise.dir = read_write;
		next_rise.shift   = {rise.shift[6:0], serial_in};
		next_rise.bit_cnt = (rise.bit_cnt == WORD_BITS) ? 4'h1 : 4'(rise.bit_cnt + 4'h1);
		// count finished words, saturating
		if (next_rise.bit_cnt == WORD_BITS && rise.words != WORDS_SAT)
			next_rise.words = 3'(rise.words + 3'h1);
	end

	// rising-edge register, cleared whenever the frame ends
	always_ff @(posedge serial_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
			rise <= '{bit_cnt: BITS_RESET, words: 3'h0, shift: 8'h00, dir: 1'b0, dir_ok: 1'b0};
		else
			rise <= next_rise;
	end

	// falling edge: hand over a finished word, mark each read bit
	always_comb
	begin
		next_fall = fall;
		// eighth falling edge of a write word, only the first four words count
		if (rise.dir_ok && !rise.dir && rise.bit_cnt == WORD_BITS && rise.words <= MAX_WORDS)
		begin
			next_fall.hold = rise.shift;
			next_fall.wtog = ~fall.wtog;
		end
		// each falling edge of a read frame moves to the next bit
		if (rise.dir_ok && rise.dir)
			next_fall.rtog = ~fall.rtog;
	end

	// falling-edge register; toggles survive frame ends so no false event appears
	always_ff @(negedge serial_clk or negedge rst_n)
	begin
		if (!rst_n)
			fall <= '{hold: 8'h00, wtog: 1'b0, rtog: 1'b0};
		else
			fall <= next_fall;
	end

	// filtered synchroniser levels
	assign act_new  = sync_filter(cur.act_sy, cur.act_f);
	assign dir_new  = sync_filter(cur.dir_sy, cur.dir_c);
	assign din_new  = sync_filter(cur.din_sy, cur.din_f);
	assign sel_new  = sync_filter(cur.sel_sy, cur.sel_f);
	assign wtog_new = sync_filter(cur.wtog_sy, cur.wtog_f);
	assign rtog_new = sync_filter(cur.rtog_sy, cur.rtog_f);
	assign act_rise = act_new & ~cur.act_f;
	// the wiper registers pause while a frame freezes its read words
	assign drain_ok = ~act_rise;
	assign pop      = pop_valid & drain_ok;

	// buffer between the crossing and the wiper registers
	word_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (cur.pend),
		.in_ready  (fifo_ready),
		.in_data   (cur.pend_word),
		.out_valid (pop_valid),
		.out_ready (drain_ok),
		.out_data  (pop_word)
	);

	// core next state
	always_comb
	begin
		next_cur         = cur;
		next_cur.act_sy  = {cur.act_sy[1:0], port_active};
		next_cur.dir_sy  = {cur.dir_sy[1:0], read_write};
		next_cur.din_sy  = {cur.din_sy[1:0], serial_in};
		next_cur.sel_sy  = {cur.sel_sy[1:0], interface_select};
		next_cur.wtog_sy = {cur.wtog_sy[1:0], fall.wtog};
		next_cur.rtog_sy = {cur.rtog_sy[1:0], fall.rtog};
		next_cur.act_f   = act_new;
		next_cur.din_f   = din_new;
		next_cur.sel_f   = sel_new;
		next_cur.wtog_f  = wtog_new;
		next_cur.rtog_f  = rtog_new;
		// frame start: fix direction and freeze read words
		if (act_rise)
		begin
			next_cur.dir_c  = dir_new;
			next_cur.rd_idx = 6'h00;
			for (int i = 0; i < POT_COUNT; i++)
				next_cur.snap[SNAP_W-1-WORD_W*i -: WORD_W] =
					pack_word(2'(i), cur.wiper[i]);
		end
		else if (!act_new)
			next_cur.rd_idx = 6'h00;
		else if (rtog_new != cur.rtog_f && cur.dir_c && cur.rd_idx != READ_BITS)
			next_cur.rd_idx = 6'(cur.rd_idx + 6'h01);
		// pending word leaves once the fifo takes it
		if (cur.pend && fifo_ready)
			next_cur.pend = 1'b0;
		// a new finished word wins over the clear above
		if (wtog_new != cur.wtog_f && !sel_new)
		begin
			next_cur.pend      = 1'b1;
			next_cur.pend_word = fall.hold;
		end
		// apply the oldest word to the wiper it names
		if (pop)
			next_cur.wiper[pop_word[7:6]] = pop_word[5:0];
		// end terminal selects follow the new positions
		for (int i = 0; i < POT_COUNT; i++)
		begin
			next_cur.hi[i] = (next_cur.wiper[i] == WIPER_MAX);
			next_cur.lo[i] = (next_cur.wiper[i] == WIPER_MIN);
		end
		// cascade output source
		if (sel_new)
			next_cur.cascade = 1'b0;
		else if (!act_new)
			next_cur.cascade = din_new;
		else if (!next_cur.dir_c)
			next_cur.cascade = 1'b0;
		else if (next_cur.rd_idx == READ_BITS)
			next_cur.cascade = 1'b0;
		else
			next_cur.cascade = next_cur.snap[~next_cur.rd_idx[4:0]];
	end

	// core register, wipers start at mid-scale
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur       <= '0;
			cur.wiper <= {POT_COUNT{WIPER_MID}};
		end
		else
			cur <= next_cur;
	end

	// outputs straight from the core register
	assign wiper_pos0  = cur.wiper[0];
	assign wiper_pos1  = cur.wiper[1];
	assign wiper_pos2  = cur.wiper[2];
	assign wiper_pos3  = cur.wiper[3];
	assign at_high_end = cur.hi;
	assign at_low_end  = cur.lo;
	assign cascade_out = cur.cascade;

	// wiper moves only when a buffered word is applied
	a_wiper_source: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cur.wiper != $past(cur.wiper)) |-> $past(pop))
		else $error("wiper changed without a word");

	// applied word lands in the named wiper
	a_word_layout: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		pop |=> cur.wiper[$past(pop_word[7:6])] == $past(pop_word[5:0]))
		else $error("word applied to wrong wiper or value");

	// high end flag of wiper zero and low end flag of wiper three track their positions
	a_end_flags: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(at_high_end[0] == (wiper_pos0 == WIPER_MAX)) && (at_low_end[3] == (wiper_pos3 == WIPER_MIN)))
		else $error("end terminal flag disagrees with position");

	// idle port passes the serial input through
	a_idle_pass: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!act_new && !sel_new) |=> cascade_out == $past(din_new))
		else $error("cascade output not passing serial input");

	// writing frame blocks the cascade output
	a_write_block: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cur.act_f && !cur.dir_c && !cur.sel_f) [*3] |-> !cascade_out)
		else $error("cascade output not blocked while writing");

	// direction stays fixed during a frame
	a_dir_fixed: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cur.act_f && $past(cur.act_f)) |-> $stable(cur.dir_c))
		else $error("direction changed inside a frame");

	// read words frozen in ascending order at frame start
	a_read_order: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		act_rise |=> (cur.rd_idx == 6'h00) && (cur.snap[31:30] == 2'h0) && (cur.snap[7:6] == 2'h3))
		else $error("read words not frozen in order");

	// other interface selected: no word is taken
	a_select_off: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(sel_new && !cur.pend) |=> !cur.pend)
		else $error("word taken while port deselected");

	// fifo back-pressure keeps the pending word
	a_pend_hold: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cur.pend && !fifo_ready) |=> cur.pend && $stable(cur.pend_word))
		else $error("pending word lost under back-pressure");

	// link: a word is finished only after eight bits
	a_word_count: assert property (
		@(negedge serial_clk) disable iff (!link_rst_n)
		(fall.wtog != $past(fall.wtog)) |-> ($past(rise.bit_cnt) == WORD_BITS))
		else $error("word finished at wrong bit count");
endmodule

/* dv/five_wire_host.sv */
// behavioural controller for the five-wire port: frames, serial clock, read capture
// assumes core_clk is the bench core clock; serial_clk pulses only inside frames
`timescale 1ns/1ps
module five_wire_host
	import wiper_port_pkg::*;
(
	// bench core clock
	input  wire logic core_clk,
	// port pins
	output logic      port_active,
	output logic      read_write,
	output logic      serial_clk,
	output logic      serial_in,
	input  wire logic cascade_out
);
	// idle pins at time zero
	initial
	begin
		port_active = 1'b0;
		serial_clk  = 1'b0;
		serial_in   = 1'b0;
	end
	// drive the data line outside frames, for the passthrough path
	task automatic set_data(input logic b);
	begin
		@(posedge core_clk);
		serial_in <= b;
	end
	endtask
	// open a frame; direction settles well before activate rises
	task automatic open_frame(input logic dir);
	begin
		@(posedge core_clk);
		read_write <= dir;
		repeat (4) @(posedge core_clk);
		port_active <= 1'b1;
		repeat (10) @(posedge core_clk);
	end
	endtask
	// one clock pulse of about 160 ns; output captured just before the fall
	task automatic pulse(input logic b, output logic got);
	begin
		@(posedge core_clk);
		serial_in <= b;
		#41.3 serial_clk = 1'b1;
		#80 got = cascade_out;
		serial_clk = 1'b0;
		// data hold over: line shows the inverse so a late sample is caught
		repeat (9) @(posedge core_clk);
		serial_in <= ~b;
	end
	endtask
	// whole word, msb first
	task automatic send_word(input word_t w);
		logic d;
	begin
		for (int i = WORD_W - 1; i >= 0; i--)
			pulse(w[i], d);
	end
	endtask
	// end of frame; clock already low
	task automatic close_frame();
	begin
		repeat (10) @(posedge core_clk);
		port_active <= 1'b0;
		repeat (10) @(posedge core_clk);
	end
	endtask
	// read pass of all four words; direction pin flips mid-frame on purpose
	task automatic read_all(output logic [SNAP_W-1:0] snap);
		logic d;
	begin
		open_frame(1'b1);
		for (int i = SNAP_W - 1; i >= 0; i--)
		begin
			pulse(1'b0, d);
			snap[i] = d;
			if (i == 20)
				read_write <= 1'b0;
		end
		close_frame();
	end
	endtask
endmodule

/* dv/tb_quad_wiper_five_wire_port.sv */
// self-checking bench for the five-wire wiper port
// assumes the host model drives every serial pin; the bench owns reset and select
`timescale 1ns/1ps
module tb_quad_wiper_five_wire_port
	import wiper_port_pkg::*;
;
	// core side
	logic       core_clk;
	logic       rst_n;
	logic       interface_select;
	// serial pins
	logic       port_active;
	logic       read_write;
	logic       serial_clk;
	logic       serial_in;
	logic       cascade_out;
	// wiper outputs
	pos_t       wiper_pos0;
	pos_t       wiper_pos1;
	pos_t       wiper_pos2;
	pos_t       wiper_pos3;
	logic [3:0] at_high_end;
	logic [3:0] at_low_end;
	// result counters
	int         fails;
	int         total_checks;

	quad_wiper_five_wire_port dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.interface_select(interface_select), .port_active(port_active),
		.read_write(read_write), .serial_clk(serial_clk), .serial_in(serial_in),
		.cascade_out(cascade_out), .wiper_pos0(wiper_pos0), .wiper_pos1(wiper_pos1),
		.wiper_pos2(wiper_pos2), .wiper_pos3(wiper_pos3), .at_high_end(at_high_end),
		.at_low_end(at_low_end));

	five_wire_host host_u (.core_clk(core_clk), .port_active(port_active),
		.read_write(read_write), .serial_clk(serial_clk), .serial_in(serial_in),
		.cascade_out(cascade_out));

	// 250 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// shared mismatch report
	task automatic note(input logic bad, input word_t got, input word_t exp);
	begin
		total_checks++;
		if (bad)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic chk_pos(input pos_t got, input pos_t exp);
		note(got !== exp, {2'h0, got}, {2'h0, exp});
	endtask
	task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
		note(got !== exp, {4'h0, got}, {4'h0, exp});
	endtask
	task automatic chk_word(input word_t got, input word_t exp);
		note(got !== exp, got, exp);
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		note(got !== exp, {7'h00, got}, {7'h00, exp});
	endtask

	// all four wipers and their end flags
	task automatic check_wipers(input pos_t e0, input pos_t e1, input pos_t e2, input pos_t e3);
		pos_t       e [4];
		logic [3:0] hi;
		logic [3:0] lo;
	begin
		e = '{e0, e1, e2, e3};
		for (int i = 0; i < POT_COUNT; i++)
		begin
			hi[i] = (e[i] === WIPER_MAX);
			lo[i] = (e[i] === WIPER_MIN);
		end
		chk_pos(wiper_pos0, e0);
		chk_pos(wiper_pos1, e1);
		chk_pos(wiper_pos2, e2);
		chk_pos(wiper_pos3, e3);
		chk_flags(at_high_end, hi);
		chk_flags(at_low_end, lo);
	end
	endtask

	// four words, out of order, both end values; output blocked while writing
	task automatic t_write();
		word_t w [4];
	begin
		w = '{{2'h3, WIPER_MAX}, {2'h0, WIPER_MIN}, {2'h2, 6'h15}, {2'h1, 6'h2A}};
		host_u.open_frame(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			host_u.send_word(w[i]);
			repeat (6) @(posedge core_clk);
			chk_bit(cascade_out, 1'b0);
		end
		// a fifth word in the same frame must be refused
		host_u.send_word({2'h0, 6'h11});
		host_u.close_frame();
		check_wipers(6'h00, 6'h2A, 6'h15, WIPER_MAX);
	end
	endtask

	// read pass returns pot0 upward in write layout
	task automatic t_read();
		logic [SNAP_W-1:0] snap;
	begin
		host_u.read_all(snap);
		chk_word(snap[31:24], {2'h0, 6'h00});
		chk_word(snap[23:16], {2'h1, 6'h2A});
		chk_word(snap[15:8], {2'h2, 6'h15});
		chk_word(snap[7:0], {2'h3, 6'h3F});
	end
	endtask

	// five bits then activate falls: nothing loads
	task automatic t_partial();
		logic d;
	begin
		host_u.open_frame(1'b0);
		// ones, so a loaded partial word would move wiper zero off 0
		for (int i = 0; i < 5; i++)
			host_u.pulse(1'b1, d);
		host_u.close_frame();
		check_wipers(6'h00, 6'h2A, 6'h15, WIPER_MAX);
	end
	endtask

	// other interface selected: write ignored, output quiet
	task automatic t_select();
	begin
		@(posedge core_clk);
		interface_select <= 1'b1;
		repeat (8) @(posedge core_clk);
		host_u.open_frame(1'b0);
		host_u.send_word({2'h2, 6'h01});
		host_u.close_frame();
		check_wipers(6'h00, 6'h2A, 6'h15, WIPER_MAX);
		host_u.set_data(1'b1);
		repeat (8) @(posedge core_clk);
		chk_bit(cascade_out, 1'b0);
		interface_select <= 1'b0;
		repeat (8) @(posedge core_clk);
	end
	endtask

	// activate low: data line reaches the cascade output
	task automatic t_pass();
	begin
		host_u.set_data(1'b1);
		repeat (8) @(posedge core_clk);
		chk_bit(cascade_out, 1'b1);
		host_u.set_data(1'b0);
		repeat (8) @(posedge core_clk);
		chk_bit(cascade_out, 1'b0);
	end
	endtask

	// reset in mid-run, inside a frame, returns every wiper to mid-scale
	task automatic t_reset();
	begin
		host_u.open_frame(1'b0);
		host_u.send_word({2'h1, 6'h05});
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		check_wipers(WIPER_MID, WIPER_MID, WIPER_MID, WIPER_MID);
		host_u.close_frame();
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		check_wipers(WIPER_MID, WIPER_MID, WIPER_MID, WIPER_MID);
	end
	endtask

	// verdict and end of run
	task automatic finish_test();
	begin
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask

	// hang guard
	initial
	begin
		#200000;
		fails++;
		finish_test();
	end

	// main sequence
	initial
	begin
		fails = 0;
		total_checks = 0;
		rst_n = 1'b0;
		interface_select = 1'b0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		check_wipers(WIPER_MID, WIPER_MID, WIPER_MID, WIPER_MID);
		t_pass();
		t_write();
		t_read();
		t_partial();
		t_select();
		t_reset();
		finish_test();
	end
endmodule
